// [ast_map.svh]
// Purpose: Register offsets, reset values and timing constants of the serial transceiver.
// Assumes: Byte-wide register port at the printed offsets.
// Notes: Definitions only.
`ifndef AST_MAP_SVH
`define AST_MAP_SVH
// ==========================================
// Clock and bit rates
`define AST_CLK_HZ 125000000
`define AST_BAUD0 115200
`define AST_BAUD1 57600
`define AST_BAUD2 38400
`define AST_BAUD3 19200
`define AST_BAUD4 9600
`define AST_BAUD5 4800
`define AST_BAUD6 2400
`define AST_BAUD7 1200
`define AST_SMP_PER_BIT 3
`define AST_SMP_LAST 2'h2
// ==========================================
// Register offsets
`define AST_OFS_FLAG 8'h16
`define AST_OFS_CTRL 8'h33
`define AST_OFS_STAT 8'h34
`define AST_OFS_TXD 8'h35
`define AST_OFS_RXDL 8'h36
`define AST_OFS_RXDH 8'h37
// ==========================================
// Reset values
`define AST_CTRL_RST 8'h02
`define AST_STAT_RST 8'h00
`define AST_FLAG_RST 8'h00
`endif

// [ast_pkg.sv]
// Purpose: Types shared by the serial transceiver.
// Assumes: Field order matches the register bit order, bit 7 first.
// Notes: Offsets and counts live in ast_map.svh.
package ast_pkg;
   // ==========================================
   // Register layouts
   typedef struct packed {
      logic inv;
      logic [1:0] fmt;
      logic [2:0] baud;
      logic tbe;
      logic tx_enable;
   } ast_ctrl_s;
   typedef struct packed {
      logic txd8;
      logic even;
      logic pen;
      logic perr;
      logic oerr;
      logic ferr;
      logic rbf;
      logic rx_enable;
   } ast_stat_s;
   typedef struct packed {
      logic [1:0] rsv_hi;
      logic rx_err;
      logic rx_done;
      logic tx_done;
      logic [2:0] rsv_lo;
   } ast_flag_s;
   // ==========================================
   // Frame sequencers
   typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} ast_frame_e;
endpackage : ast_pkg

// [ast_uart.sv]
// Purpose: Full-duplex asynchronous serial transceiver with byte-wide register port.
// Assumes: Single 125 MHz clock, synchronous active-high reset.
// Notes: Three samples per bit; bit time is three baud ticks.
`timescale 1ns/1ps
`include "ast_map.svh"

module ast_uart
   import ast_pkg::*;
#(
   parameter int BAUD_DIV [8] = '{
      `AST_CLK_HZ / (`AST_SMP_PER_BIT * `AST_BAUD0),
      `AST_CLK_HZ / (`AST_SMP_PER_BIT * `AST_BAUD1),
      `AST_CLK_HZ / (`AST_SMP_PER_BIT * `AST_BAUD2),
      `AST_CLK_HZ / (`AST_SMP_PER_BIT * `AST_BAUD3),
      `AST_CLK_HZ / (`AST_SMP_PER_BIT * `AST_BAUD4),
      `AST_CLK_HZ / (`AST_SMP_PER_BIT * `AST_BAUD5),
      `AST_CLK_HZ / (`AST_SMP_PER_BIT * `AST_BAUD6),
      `AST_CLK_HZ / (`AST_SMP_PER_BIT * `AST_BAUD7)
   }
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Serial line
   input wire logic rx_pin,
   output logic tx_pin,
   // Event flags toward the interrupt controller
   output logic tx_done_flag,
   output logic rx_done_flag,
   output logic rx_error_flag,
   output logic rx_buf_full
);

   // ==========================================
   // Registers and nets
   ast_ctrl_s ctrl_ff;
   ast_stat_s stat_ff;
   ast_flag_s flag_ff;
   logic [7:0] rdata_ff;
   logic [15:0] div_cnt_ff;
   logic tick;
   logic [15:0] div_last;
   logic [8:0] tx_hold_ff;
   ast_frame_e tx_st_ff;
   logic [1:0] tx_ph_ff;
   logic [3:0] tx_cnt_ff;
   logic [3:0] tx_nb_ff;
   logic tx_pen_ff;
   logic tx_par_ff;
   logic [8:0] tx_sh_ff;
   logic tx_pin_ff;
   logic tx_load;
   logic tx_end;
   logic tx_bit_end;
   logic tx_line;
   logic [8:0] tx_mask;
   logic [3:0] cur_nb;
   logic cur_pen;
   logic rx_s1_ff;
   logic rx_s2_ff;
   logic rx_in;
   logic rx_prev_ff;
   ast_frame_e rx_st_ff;
   logic [1:0] rx_ph_ff;
   logic [1:0] rx_smp_ff;
   logic [3:0] rx_cnt_ff;
   logic [3:0] rx_nb_ff;
   logic rx_pen_ff;
   logic [8:0] rx_sh_ff;
   logic rx_par_ff;
   logic [8:0] rxd_ff;
   logic rx_maj;
   logic rx_bit_end;
   logic rx_end;
   logic rx_stop_bit;
   logic perr_ev;
   logic ferr_ev;
   logic oerr_ev;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_txd;
   logic wr_flag;
   logic rd_rxdl;

   // ==========================================
   // Register decode
   assign wr_ctrl = reg_wr && (reg_addr == `AST_OFS_CTRL);
   assign wr_stat = reg_wr && (reg_addr == `AST_OFS_STAT);
   assign wr_txd = reg_wr && (reg_addr == `AST_OFS_TXD);
   assign wr_flag = reg_wr && (reg_addr == `AST_OFS_FLAG);
   assign rd_rxdl = reg_rd && (reg_addr == `AST_OFS_RXDL);

   // Format code to data bit count
   always_comb begin
      case (ctrl_ff.fmt)
         2'h2: cur_nb = 4'h8;
         2'h3: cur_nb = 4'h9;
         default: cur_nb = 4'h7;
      endcase
      cur_pen = stat_ff.pen && (ctrl_ff.fmt != 2'h3);
   end

   // ==========================================
   // Baud generator
   assign div_last = 16'(BAUD_DIV[ctrl_ff.baud] - 1);
   assign tick = (div_cnt_ff >= div_last);

   always_ff @(posedge clk) begin
      if (sys_rst || tick) begin
         div_cnt_ff <= 16'h0000;
      end else begin
         div_cnt_ff <= div_cnt_ff + 16'h0001;
      end
   end

   // ==========================================
   // Control register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_ff <= ast_ctrl_s'(`AST_CTRL_RST);
      end else begin
         if (wr_ctrl) begin
            ctrl_ff.inv <= reg_wdata[7];
            ctrl_ff.fmt <= reg_wdata[6:5];
            ctrl_ff.baud <= reg_wdata[4:2];
            ctrl_ff.tx_enable <= reg_wdata[0];
         end
         // Write into the holding register wins over the engine taking it
         if (wr_txd) begin
            ctrl_ff.tbe <= 1'b0;
         end else if (tx_load) begin
            ctrl_ff.tbe <= 1'b1;
         end
      end
   end

   // ==========================================
   // Transmit holding register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tx_hold_ff <= 9'h000;
      end else if (wr_txd) begin
         tx_hold_ff <= {stat_ff.txd8, reg_wdata};
      end
   end

   // ==========================================
   // Transmit sequencer
   assign tx_load = tick && (tx_st_ff == ST_IDLE) && ctrl_ff.tx_enable && !ctrl_ff.tbe;
   assign tx_bit_end = tick && (tx_ph_ff == `AST_SMP_LAST);
   assign tx_end = tx_bit_end && (tx_st_ff == ST_STOP);
   assign tx_mask = 9'(9'h1FF >> (4'h9 - cur_nb));

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tx_st_ff <= ST_IDLE;
         tx_ph_ff <= 2'h0;
         tx_cnt_ff <= 4'h0;
         tx_nb_ff <= 4'h0;
         tx_pen_ff <= 1'b0;
         tx_par_ff <= 1'b0;
         tx_sh_ff <= 9'h000;
      end else if (tx_load) begin
         tx_st_ff <= ST_START;
         tx_ph_ff <= 2'h0;
         tx_cnt_ff <= 4'h0;
         tx_nb_ff <= cur_nb;
         tx_pen_ff <= cur_pen;
         tx_sh_ff <= tx_hold_ff & tx_mask;
         // Even: total ones even; odd: total ones odd
         tx_par_ff <= (^(tx_hold_ff & tx_mask)) ^ ~stat_ff.even;
      end else if (tick && (tx_st_ff != ST_IDLE)) begin
         if (tx_ph_ff == `AST_SMP_LAST) begin
            tx_ph_ff <= 2'h0;
            case (tx_st_ff)
               ST_START: begin
                  tx_st_ff <= ST_DATA;
               end
               ST_DATA: begin
                  tx_sh_ff <= tx_sh_ff >> 1;
                  tx_cnt_ff <= tx_cnt_ff + 4'h1;
                  if (tx_cnt_ff == tx_nb_ff - 4'h1) begin
                     tx_st_ff <= tx_pen_ff ? ST_PAR : ST_STOP;
                  end
               end
               ST_PAR: begin
                  tx_st_ff <= ST_STOP;
               end
               ST_STOP: begin
                  tx_st_ff <= ST_IDLE;
               end
               default: begin
                  tx_st_ff <= ST_IDLE;
               end
            endcase
         end else begin
            tx_ph_ff <= tx_ph_ff + 2'h1;
         end
      end
   end

   // Line level per state
   always_comb begin
      case (tx_st_ff)
         ST_START: tx_line = 1'b0;
         ST_DATA: tx_line = tx_sh_ff[0];
         ST_PAR: tx_line = tx_par_ff;
         default: tx_line = 1'b1;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tx_pin_ff <= 1'b1;
      end else begin
         tx_pin_ff <= tx_line ^ ctrl_ff.inv;
      end
   end

   assign tx_pin = tx_pin_ff;

   // ==========================================
   // Receive input synchroniser
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_s1_ff <= 1'b1;
         rx_s2_ff <= 1'b1;
      end else begin
         rx_s1_ff <= rx_pin;
         rx_s2_ff <= rx_s1_ff;
      end
   end

   assign rx_in = rx_s2_ff ^ ctrl_ff.inv;

   // Line level seen at the previous tick
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_prev_ff <= 1'b1;
      end else if (tick) begin
         rx_prev_ff <= rx_in;
      end
   end

   // ==========================================
   // Receive sequencer
   assign rx_maj = (rx_smp_ff[0] & rx_smp_ff[1]) | (rx_smp_ff[0] & rx_in) | (rx_smp_ff[1] & rx_in);
   assign rx_bit_end = tick && (rx_ph_ff == `AST_SMP_LAST);
   assign rx_end = rx_bit_end && (rx_st_ff == ST_STOP) && stat_ff.rx_enable;
   assign rx_stop_bit = rx_maj;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_st_ff <= ST_IDLE;
         rx_ph_ff <= 2'h0;
         rx_smp_ff <= 2'h3;
         rx_cnt_ff <= 4'h0;
         rx_nb_ff <= 4'h0;
         rx_pen_ff <= 1'b0;
         rx_sh_ff <= 9'h000;
         rx_par_ff <= 1'b0;
      end else if (!stat_ff.rx_enable) begin
         rx_st_ff <= ST_IDLE;
         rx_ph_ff <= 2'h0;
      end else if (tick) begin
         if (rx_st_ff == ST_IDLE) begin
            // Falling edge between ticks starts the start-bit vote
            if (rx_prev_ff && !rx_in) begin
               rx_st_ff <= ST_START;
               rx_ph_ff <= 2'h1;
               rx_smp_ff <= {1'b1, rx_in};
               rx_cnt_ff <= 4'h0;
               rx_nb_ff <= cur_nb;
               rx_pen_ff <= cur_pen;
               rx_sh_ff <= 9'h000;
            end
         end else if (rx_ph_ff == 2'h0) begin
            rx_smp_ff[0] <= rx_in;
            rx_ph_ff <= 2'h1;
         end else if (rx_ph_ff == 2'h1) begin
            rx_smp_ff[1] <= rx_in;
            rx_ph_ff <= 2'h2;
         end else begin
            rx_ph_ff <= 2'h0;
            case (rx_st_ff)
               ST_START: begin
                  rx_st_ff <= rx_maj ? ST_IDLE : ST_DATA;
               end
               ST_DATA: begin
                  rx_sh_ff[rx_cnt_ff] <= rx_maj;
                  rx_cnt_ff <= rx_cnt_ff + 4'h1;
                  if (rx_cnt_ff == rx_nb_ff - 4'h1) begin
                     rx_st_ff <= rx_pen_ff ? ST_PAR : ST_STOP;
                  end
               end
               ST_PAR: begin
                  rx_par_ff <= rx_maj;
                  rx_st_ff <= ST_STOP;
               end
               ST_STOP: begin
                  rx_st_ff <= ST_IDLE;
               end
               default: begin
                  rx_st_ff <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // ==========================================
   // Receive checks
   assign perr_ev = rx_pen_ff && ((^{rx_sh_ff, rx_par_ff}) != ~stat_ff.even);
   assign ferr_ev = !rx_stop_bit;
   assign oerr_ev = stat_ff.rbf;

   // Receive data register, second stage of the double buffer
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rxd_ff <= 9'h000;
      end else if (rx_end) begin
         rxd_ff <= rx_sh_ff;
      end
   end

   // ==========================================
   // Status register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stat_ff <= ast_stat_s'(`AST_STAT_RST);
      end else begin
         if (wr_stat) begin
            stat_ff.txd8 <= reg_wdata[7];
            stat_ff.even <= reg_wdata[6];
            stat_ff.pen <= reg_wdata[5];
            stat_ff.rx_enable <= reg_wdata[0];
         end
         // Software clears error bits; a new error in the same cycle wins
         stat_ff.perr <= (wr_stat ? reg_wdata[4] : stat_ff.perr) | (rx_end && perr_ev);
         stat_ff.oerr <= (wr_stat ? reg_wdata[3] : stat_ff.oerr) | (rx_end && oerr_ev);
         stat_ff.ferr <= (wr_stat ? reg_wdata[2] : stat_ff.ferr) | (rx_end && ferr_ev);
         if (rx_end) begin
            stat_ff.rbf <= 1'b1;
         end else if (rd_rxdl) begin
            stat_ff.rbf <= 1'b0;
         end
      end
   end

   // ==========================================
   // Event flag register, write 0 to clear, set wins
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flag_ff <= ast_flag_s'(`AST_FLAG_RST);
      end else begin
         flag_ff.tx_done <= (flag_ff.tx_done & ~(wr_flag & ~reg_wdata[3])) | tx_end;
         flag_ff.rx_done <= (flag_ff.rx_done & ~(wr_flag & ~reg_wdata[4])) | rx_end;
         flag_ff.rx_err <= (flag_ff.rx_err & ~(wr_flag & ~reg_wdata[5]))
                           | (rx_end && (perr_ev || ferr_ev || oerr_ev
                              || stat_ff.perr || stat_ff.oerr || stat_ff.ferr));
      end
   end

   assign tx_done_flag = flag_ff.tx_done;
   assign rx_done_flag = flag_ff.rx_done;
   assign rx_error_flag = flag_ff.rx_err;
   assign rx_buf_full = stat_ff.rbf;

   // ==========================================
   // Read data, one cycle after the strobe
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `AST_OFS_FLAG: rdata_ff <= {2'h0, flag_ff.rx_err, flag_ff.rx_done, flag_ff.tx_done, 3'h0};
            `AST_OFS_CTRL: rdata_ff <= ctrl_ff;
            `AST_OFS_STAT: rdata_ff <= {1'b0, stat_ff[6:0]};
            `AST_OFS_RXDL: rdata_ff <= rxd_ff[7:0];
            `AST_OFS_RXDH: rdata_ff <= {rxd_ff[8], 7'h00};
            default: rdata_ff <= 8'h00;
         endcase
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   assign reg_rdata = rdata_ff;

endmodule : ast_uart

// [ast_uart_properties.sv]
// Purpose: Port-level properties of the serial transceiver.
// Assumes: Bit time of at least eight clocks; line not inverted.
// Notes: Bound to ast_uart from the testbench top file.
`timescale 1ns/1ps
module ast_uart_properties (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Serial line
   input wire logic rx_pin,
   input wire logic tx_pin,
   // Event flags
   input wire logic tx_done_flag,
   input wire logic rx_done_flag,
   input wire logic rx_error_flag,
   input wire logic rx_buf_full
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // ==========================================
   // Register port
   property p_rdata_idle;
      !reg_rd |=> reg_rdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
   property p_flag_read;
      reg_rd && reg_addr == 8'h16 |=> reg_rdata[5:3] == {$past(rx_error_flag), $past(rx_done_flag), $past(tx_done_flag)};
   endproperty
   a_flag_read: assert property (p_flag_read) else $error("flag read mismatch");
   // ==========================================
   // Receive buffer
   property p_rbf_clear;
      reg_rd && reg_addr == 8'h36 |=> !rx_buf_full;
   endproperty
   a_rbf_clear: assert property (p_rbf_clear) else $error("buffer full kept after read");
   property p_rbf_hold;
      rx_buf_full && !(reg_rd && reg_addr == 8'h36) |=> rx_buf_full;
   endproperty
   a_rbf_hold: assert property (p_rbf_hold) else $error("buffer full lost");
   property p_rbf_done;
      $rose(rx_buf_full) |-> rx_done_flag;
   endproperty
   a_rbf_done: assert property (p_rbf_done) else $error("buffer full without done");
   property p_err_done;
      $rose(rx_error_flag) |-> rx_done_flag && rx_buf_full;
   endproperty
   a_err_done: assert property (p_err_done) else $error("error flag outside completion");
   // ==========================================
   // Transmit line and event coverage
   property p_start_len;
      $fell(tx_pin) |-> !tx_pin [*8];
   endproperty
   a_start_len: assert property (p_start_len) else $error("start bit too short");
   property p_bit_len;
      $changed(tx_pin) |=> $stable(tx_pin) [*7];
   endproperty
   a_bit_len: assert property (p_bit_len) else $error("line bit too short");
   c_tx_done: cover property ($rose(tx_done_flag));
   c_rx_err: cover property ($rose(rx_error_flag));
   c_rbf_read: cover property (rx_buf_full && reg_rd && reg_addr == 8'h36);
endmodule : ast_uart_properties

// [ast_link_model.sv]
// Purpose: Remote serial partner on the transmit and receive lines.
// Assumes: Rate set by bit_clks, captured frame length by frame_len.
// Notes: Captured frames queue in got_q, bit 0 first.
`timescale 1ns/1ps
module ast_link_model (
   // Clock
   input wire logic clk,
   // Serial lines
   input wire logic tx_line,
   output logic rx_line
);
   int bit_clks = 12;
   int frame_len = 10;
   logic [11:0] cap;
   logic [11:0] got_q [$];
   initial rx_line = 1'b1;
   // ==========================================
   // Toward the device
   task automatic send(input logic [11:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         rx_line <= bits[i];
         repeat (bit_clks - 1) @(posedge clk);
      end
      @(posedge clk);
      rx_line <= 1'b1;
   endtask : send
   task automatic pulse(input int clks);
      @(posedge clk);
      rx_line <= 1'b0;
      repeat (clks) @(posedge clk);
      rx_line <= 1'b1;
   endtask : pulse
   // ==========================================
   // From the device, sampled mid-bit
   initial forever begin
      @(negedge tx_line);
      cap = 12'hFFF;
      repeat (bit_clks / 2) @(posedge clk);
      for (int i = 0; i < frame_len; i++) begin
         cap[i] = tx_line;
         if (i < frame_len - 1) repeat (bit_clks) @(posedge clk);
      end
      got_q.push_back(cap);
   end
endmodule : ast_link_model

// [ast_uart_test.sv]
// Purpose: Self-checking bench of the serial transceiver.
// Assumes: Short baud dividers; partner model on both lines.
// Notes: Expected frames and data built here from the format settings.
`timescale 1ns/1ps
module ast_uart_test;
   localparam int DIV [8] = '{4, 5, 6, 7, 8, 9, 10, 11};
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic rx_pin;
   logic tx_pin;
   logic tx_done_flag;
   logic rx_done_flag;
   logic rx_error_flag;
   logic rx_buf_full;
   logic [15:0] rnd = 16'hF620;
   int n_errors = 0;
   int n_compared = 0;
   logic [1:0] fmt = 2'b10;
   logic pen = 1'b0;
   logic even = 1'b0;
   logic [7:0] v;
   always #4 clk = ~clk;
   ast_uart #(.BAUD_DIV(DIV)) dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin(rx_pin), .tx_pin(tx_pin),
      .tx_done_flag(tx_done_flag), .rx_done_flag(rx_done_flag), .rx_error_flag(rx_error_flag),
      .rx_buf_full(rx_buf_full));
   ast_link_model link (.clk(clk), .tx_line(tx_pin), .rx_line(rx_pin));
   // ==========================================
   // Helpers
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic logic [11:0] frame(input logic [8:0] d, output int n, output logic [8:0] m);
      int w;
      w = (fmt == 2'b11) ? 9 : (fmt == 2'b10) ? 8 : 7;
      m = d & ((9'h001 << w) - 9'h001);
      frame = 12'hFFE;
      for (int i = 0; i < w; i++) frame[i + 1] = m[i];
      n = w + 2;
      if (pen && fmt != 2'b11) begin
         frame[w + 1] = even ? ^m : ~^m;
         n = w + 3;
      end
   endfunction : frame
   task automatic stop_test;
      $display("Compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wait_sig(input int sel, input int need, input int lim);
      int i;
      for (i = 0; i < lim; i++) begin
         if ((sel == 0 && tx_done_flag === 1'b1) || (sel == 1 && rx_done_flag === 1'b1)) break;
         if (sel == 2 && link.got_q.size() >= need) break;
         @(posedge clk);
      end
      if (i == lim) begin
         n_errors++;
         $display("CHECK FAILED wait %0d expected event seen timeout", sel);
         stop_test();
      end
   endtask : wait_sig
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask : rd
   task automatic cfg(input logic [1:0] f, input int b, input logic p, input logic e, input logic tx, input logic rx);
      fmt = f;
      pen = p;
      even = e;
      link.bit_clks = 3 * DIV[b];
      wr(8'h33, {1'b0, f, b[2:0], 1'b0, tx});
      wr(8'h34, {1'b0, e, p, 4'h0, rx});
   endtask : cfg
   task automatic rx_one(input logic [11:0] flip, input logic [2:0] errs, input bit rd_it);
      logic [8:0] m;
      logic [11:0] f;
      int n;
      rnd = lfsr(rnd);
      f = frame(rnd[8:0], n, m) ^ flip;
      wr(8'h16, 8'h00);
      link.send(f, n);
      wait_sig(1, 1, 200);
      rd(8'h34, v);
      chk("status", {5'h00, even, pen, errs, 2'b11}, {4'h0, v});
      chk("error flag", {11'h000, |errs}, {11'h000, rx_error_flag});
      if (rd_it) begin
         rd(8'h36, v);
         chk("rx low", {4'h0, m[7:0]}, {4'h0, v});
         rd(8'h37, v);
         chk("rx high", {4'h0, m[8], 7'h00}, {4'h0, v});
         chk("buf full", 12'h000, {11'h000, rx_buf_full});
      end
   endtask : rx_one
   // ==========================================
   // Main sequence
   initial begin
      logic [7:0] ra [5];
      logic [7:0] rv [5];
      logic [8:0] m;
      logic [11:0] f;
      int n;
      ra = '{8'h33, 8'h34, 8'h16, 8'h35, 8'h7F};
      rv = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      wr(8'h7F, 8'hFF);
      foreach (ra[i]) begin
         rd(ra[i], v);
         chk("reset value", {4'h0, rv[i]}, {4'h0, v});
      end
      wr(8'h33, 8'h80);
      rd(8'h33, v);
      chk("invert", 12'h082, {3'h0, tx_pin, v});
      repeat (10) @(posedge clk);
      wr(8'h33, 8'h00);
      repeat (150) @(posedge clk);
      link.got_q.delete();
      for (int k = 0; k < 8; k++) begin
         rnd = lfsr(rnd);
         cfg(k[1:0], k, k[2], rnd[9], 1'b0, 1'b0);
         f = frame(rnd[8:0], n, m);
         link.frame_len = n;
         wr(8'h34, {rnd[8], even, pen, 5'h00});
         wr(8'h35, rnd[7:0]);
         rd(8'h33, v);
         chk("ctrl", {4'h0, 1'b0, fmt, k[2:0], 2'b00}, {4'h0, v});
         chk("idle frames", 12'h000, 12'(link.got_q.size()));
         wr(8'h16, 8'h00);
         wr(8'h33, {1'b0, fmt, k[2:0], 2'b01});
         wait_sig(2, 1, 2000);
         chk("tx done early", 12'h000, {11'h000, tx_done_flag});
         chk("tx frame", f, link.got_q.pop_front());
         wait_sig(0, 1, 200);
         chk("tx done", 12'h001, {11'h000, tx_done_flag});
      end
      cfg(2'b10, 0, 1'b0, 1'b0, 1'b1, 1'b0);
      link.frame_len = 10;
      wr(8'h35, 8'hA5);
      for (int i = 0; i < 100; i++) begin
         rd(8'h33, v);
         if (v[1]) break;
      end
      wr(8'h35, 8'h3C);
      chk("tbe", 12'h001, {11'h000, v[1]});
      wait_sig(2, 2, 2000);
      chk("first", frame(9'h0A5, n, m), link.got_q.pop_front());
      chk("second", frame(9'h03C, n, m), link.got_q.pop_front());
      cfg(2'b10, 2, 1'b0, 1'b0, 1'b0, 1'b0);
      wr(8'h16, 8'h00);
      link.send(frame(9'h055, n, m), n);
      repeat (60) @(posedge clk);
      chk("rx off", 12'h000, {11'h000, rx_done_flag});
      cfg(2'b10, 2, 1'b1, 1'b1, 1'b0, 1'b1);
      link.pulse(4);
      repeat (60) @(posedge clk);
      chk("glitch", 12'h000, {11'h000, rx_done_flag});
      rx_one(12'h000, 3'b000, 1'b1);
      rx_one(12'h200, 3'b100, 1'b0);
      rx_one(12'h000, 3'b110, 1'b1);
      wr(8'h34, {1'b0, even, pen, 4'h0, 1'b1});
      rx_one(12'h400, 3'b001, 1'b1);
      cfg(2'b01, 1, 1'b1, 1'b0, 1'b0, 1'b1);
      rx_one(12'h000, 3'b000, 1'b1);
      cfg(2'b11, 3, 1'b1, 1'b0, 1'b0, 1'b1);
      rx_one(12'h000, 3'b000, 1'b1);
      stop_test();
   end
endmodule : ast_uart_test

bind ast_uart ast_uart_properties u_props (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin(rx_pin),
   .tx_pin(tx_pin), .tx_done_flag(tx_done_flag), .rx_done_flag(rx_done_flag),
   .rx_error_flag(rx_error_flag), .rx_buf_full(rx_buf_full));
